// ===== src/scd_decoder.sv
/*
 * Command word decoder of the synthesizer: three-wire and two-wire serial
 * receivers, decimal scaling and the five destination registers.
 * Assumes asynchronous pins, sampled by core_clk at 25 MHz; the two-wire
 * data pin is open drain with an external pull-up.
 */
`timescale 1ns/1ns
// Functional notes
// - A three-wire command is one 32-bit word: select, multiplier, value.
// - The low 24 bits are an unsigned frequency or channel value.
// - The value is multiplied by ten to the power of the multiplier field.
// - Scaling completes before the result goes to the selected register.
// - Select code zero loads the channel-number register.
// - Select code one loads the start-frequency register.
// - Select code two loads the stop-frequency register.
// - Select code three loads the step-size register.
// - Select code four loads the reference-frequency register.
// - Operating frequency is start plus channel times step.
// - A two-wire command is five acknowledged bytes, address byte first.
// - A command counts only at STOP; a START first discards it.
module scd_decoder #(
    parameter logic [6:0] SLAVE_ADDR = 7'h3A // arbitrary default address
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic da0_in,
    input wire logic da1_in,
    input wire logic da2_in,
    input wire logic i2c_mode,
    output logic da0_out,
    output logic da0_oe,
    output logic [scd_pkg::SCD_SCALE_W-1:0] channel_num,
    output logic [scd_pkg::SCD_SCALE_W-1:0] start_freq,
    output logic [scd_pkg::SCD_SCALE_W-1:0] stop_freq,
    output logic [scd_pkg::SCD_SCALE_W-1:0] step_freq,
    output logic [scd_pkg::SCD_SCALE_W-1:0] ref_freq,
    output logic [scd_pkg::SCD_SCALE_W-1:0] op_freq,
    output logic reg_update
);
    import scd_pkg::*;

    typedef enum logic [1:0] {
        SCD_I2_IDLE = 2'b00,
        SCD_I2_RECV = 2'b01,
        SCD_I2_ACK = 2'b10,
        SCD_I2_SKIP = 2'b11
    } scd_i2_e;

    logic [SCD_PIN_N-1:0] pin_meta;
    logic [SCD_PIN_N-1:0] pin_sync;
    logic [SCD_PIN_N-1:0] pin_prev;
    logic mode;
    logic tw_cs_n;
    logic tw_clk_rise;
    logic cs_rise;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [SCD_WORD_W-1:0] tw_shift;
    logic [5:0] tw_cnt;
    logic tw_go;
    scd_i2_e i2_state;
    logic [3:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [7:0] byte_shift;
    logic [SCD_WORD_W-1:0] i2_word;
    logic i2_go;
    logic go;
    scd_cmd_s cmd;
    logic sc_busy;
    logic sc_done;
    scd_scaled_s sc_res;

    // two-stage synchronisers, one per pin
    genvar g;
    generate
        for (g = 0; g < SCD_PIN_N; g++) begin : g_sync
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    pin_meta[g] <= 1'b1;
                    pin_sync[g] <= 1'b1;
                    pin_prev[g] <= 1'b1;
                end else begin
                    pin_meta[g] <= (g == SCD_PIN_DA0) ? da0_in :
                                   (g == SCD_PIN_DA1) ? da1_in :
                                   (g == SCD_PIN_DA2) ? da2_in : i2c_mode;
                    pin_sync[g] <= pin_meta[g];
                    pin_prev[g] <= pin_sync[g];
                end
            end
        end
    endgenerate

    // edge and condition detection on synchronised pins only
    assign mode = pin_sync[SCD_PIN_MODE];
    assign tw_cs_n = pin_sync[SCD_PIN_DA0];
    assign tw_clk_rise = pin_sync[SCD_PIN_DA2] && !pin_prev[SCD_PIN_DA2];
    assign cs_rise = tw_cs_n && !pin_prev[SCD_PIN_DA0];
    assign scl_rise = pin_sync[SCD_PIN_DA1] && !pin_prev[SCD_PIN_DA1];
    assign scl_fall = !pin_sync[SCD_PIN_DA1] && pin_prev[SCD_PIN_DA1];
    assign start_det = pin_sync[SCD_PIN_DA1] && pin_prev[SCD_PIN_DA1]
                       && pin_prev[SCD_PIN_DA0] && !pin_sync[SCD_PIN_DA0];
    assign stop_det = pin_sync[SCD_PIN_DA1] && pin_prev[SCD_PIN_DA1]
                      && !pin_prev[SCD_PIN_DA0] && pin_sync[SCD_PIN_DA0];

    // three-wire shifter; count saturates so long frames are rejected
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tw_shift <= '0;
            tw_cnt <= '0;
        end else if (mode || tw_cs_n) begin
            tw_cnt <= '0;
        end else if (tw_clk_rise) begin
            tw_shift <= {tw_shift[SCD_WORD_W-2:0], pin_sync[SCD_PIN_DA1]};
            tw_cnt <= (tw_cnt == SCD_TW_SAT) ? SCD_TW_SAT : tw_cnt + 6'h1;
        end
    end

    // act only when select ends a frame of exactly 32 bits
    assign tw_go = !mode && cs_rise && (tw_cnt == SCD_TW_BITS);

    // two-wire receiver: listen, acknowledge matching bytes, never read
    always_ff @(posedge core_clk) begin
        if (rst) begin
            i2_state <= SCD_I2_IDLE;
            bit_cnt <= '0;
            byte_cnt <= '0;
            byte_shift <= '0;
            i2_word <= '0;
            da0_oe <= 1'b0;
        end else if (!mode || stop_det) begin
            i2_state <= SCD_I2_IDLE;
            da0_oe <= 1'b0;
        end else if (start_det) begin
            i2_state <= SCD_I2_RECV;
            bit_cnt <= '0;
            byte_cnt <= '0;
            da0_oe <= 1'b0;
        end else begin
            unique case (i2_state)
                SCD_I2_IDLE, SCD_I2_SKIP: begin
                end
                SCD_I2_RECV: begin
                    if (scl_rise && bit_cnt != SCD_BYTE_BITS) begin
                        byte_shift <= {byte_shift[6:0], pin_sync[SCD_PIN_DA0]};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == SCD_BYTE_BITS) begin
                        bit_cnt <= '0;
                        if (byte_cnt != 3'h0 ||
                            byte_shift == {SLAVE_ADDR, 1'b0}) begin
                            da0_oe <= 1'b1;
                            byte_cnt <= byte_cnt + 3'h1;
                            i2_state <= SCD_I2_ACK;
                            if (byte_cnt != 3'h0) begin
                                i2_word <= {i2_word[23:0], byte_shift};
                            end
                        end else begin
                            i2_state <= SCD_I2_SKIP;
                        end
                    end
                end
                SCD_I2_ACK: begin
                    if (scl_fall) begin
                        da0_oe <= 1'b0;
                        i2_state <= (byte_cnt == SCD_I2C_BYTES) ?
                                    SCD_I2_SKIP : SCD_I2_RECV;
                    end
                end
            endcase
        end
    end

    // a command is accepted only at STOP after five bytes
    assign i2_go = mode && stop_det && (byte_cnt == SCD_I2C_BYTES)
                   && (i2_state == SCD_I2_SKIP);
    assign go = tw_go || i2_go;
    assign cmd = mode ? i2_word : tw_shift;

    scd_scaler u_scaler (
        .core_clk(core_clk),
        .rst(rst),
        .go(go),
        .cmd(cmd),
        .busy(sc_busy),
        .done(sc_done),
        .res(sc_res)
    );

    // route the scaled result; reserved codes write nothing
    always_ff @(posedge core_clk) begin
        if (rst) begin
            channel_num <= SCD_RST_CHAN;
            start_freq <= SCD_RST_START;
            stop_freq <= SCD_RST_STOP;
            step_freq <= SCD_RST_STEP;
            ref_freq <= SCD_RST_REF;
            reg_update <= 1'b0;
        end else begin
            reg_update <= sc_done;
            if (sc_done) begin
                case (sc_res.dest)
                    SCD_DST_CHAN: channel_num <= sc_res.value;
                    SCD_DST_START: start_freq <= sc_res.value;
                    SCD_DST_STOP: stop_freq <= sc_res.value;
                    SCD_DST_STEP: step_freq <= sc_res.value;
                    SCD_DST_REF: ref_freq <= sc_res.value;
                    default: reg_update <= 1'b0;
                endcase
            end
        end
    end

    // operating frequency, truncated to the register width
    always_ff @(posedge core_clk) begin
        if (rst) begin
            op_freq <= SCD_RST_START;
            da0_out <= 1'b0;
        end else begin
            op_freq <= start_freq + SCD_SCALE_W'(channel_num * step_freq);
            da0_out <= 1'b0;
        end
    end

    property p_tw_len;
        @(posedge core_clk) disable iff (rst)
        tw_go |-> tw_cnt == SCD_TW_BITS && !mode;
    endproperty
    a_tw_len: assert property (p_tw_len)
        else $error("three-wire command acted without 32 bits");

    property p_fields;
        @(posedge core_clk) disable iff (rst)
        (go && !mode) |-> cmd.dest_select_field == tw_shift[31:28]
                          && cmd.mult == tw_shift[27:24];
    endproperty
    a_fields: assert property (p_fields)
        else $error("command fields not taken from the right bits");

    property p_chan;
        @(posedge core_clk) disable iff (rst)
        (sc_done && sc_res.dest == 4'h0) |=>
            channel_num == $past(sc_res.value) && reg_update;
    endproperty
    a_chan: assert property (p_chan)
        else $error("channel register not loaded");

    property p_start;
        @(posedge core_clk) disable iff (rst)
        (sc_done && sc_res.dest == 4'h1) |=> start_freq == $past(sc_res.value);
    endproperty
    a_start: assert property (p_start)
        else $error("start register not loaded");

    property p_stop;
        @(posedge core_clk) disable iff (rst)
        (sc_done && sc_res.dest == 4'h2) |=> stop_freq == $past(sc_res.value);
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop register not loaded");

    property p_step;
        @(posedge core_clk) disable iff (rst)
        (sc_done && sc_res.dest == 4'h3) |=> step_freq == $past(sc_res.value);
    endproperty
    a_step: assert property (p_step)
        else $error("step register not loaded");

    property p_ref;
        @(posedge core_clk) disable iff (rst)
        (sc_done && sc_res.dest == 4'h4) |=> ref_freq == $past(sc_res.value);
    endproperty
    a_ref: assert property (p_ref)
        else $error("reference register not loaded");

    property p_op;
        @(posedge core_clk) disable iff (rst)
        // op_freq lags one edge, so it only matches unchanged registers
        $stable(channel_num) && $stable(step_freq) && $stable(start_freq)
        |-> op_freq == start_freq + SCD_SCALE_W'(channel_num * step_freq);
    endproperty
    a_op: assert property (p_op)
        else $error("operating frequency wrong");

    property p_scale_first;
        @(posedge core_clk) disable iff (rst)
        go && !sc_busy |=> sc_busy && !sc_done ##[1:16] sc_done;
    endproperty
    a_scale_first: assert property (p_scale_first)
        else $error("result delivered before scaling finished");

    property p_purge;
        @(posedge core_clk) disable iff (rst)
        (mode && start_det && !stop_det) |=> byte_cnt == 3'h0 ##1 !i2_go;
    endproperty
    a_purge: assert property (p_purge)
        else $error("partial command not discarded on START");

    c_tw: cover property (@(posedge core_clk) disable iff (rst) tw_go);
    c_i2: cover property (@(posedge core_clk) disable iff (rst) i2_go);
    c_ack: cover property (@(posedge core_clk) disable iff (rst)
        $rose(da0_oe));
    c_rsv: cover property (@(posedge core_clk) disable iff (rst)
        sc_done && sc_res.dest > 4'h4);
endmodule

// ===== src/scd_pkg.sv
/*
 * Shared constants and types for the synthesizer command word decoder.
 * Assumes a single core clock domain; pins are synchronised in the top.
 */
package scd_pkg;
    // command word layout, most significant bit sent first
    localparam int SCD_WORD_W = 32;
    localparam int SCD_SEL_W = 4;
    localparam int SCD_MUL_W = 4;
    localparam int SCD_VAL_W = 24;
    // widest scaled value: (2^24 - 1) * 10^15 fits in 74 bits
    localparam int SCD_SCALE_W = 76;
    localparam logic [5:0] SCD_TW_BITS = 6'h20;
    localparam logic [5:0] SCD_TW_SAT = 6'h21;
    localparam logic [2:0] SCD_I2C_BYTES = 3'h5;
    localparam logic [3:0] SCD_BYTE_BITS = 4'h8;
    // synchronised pin positions
    localparam int SCD_PIN_DA0 = 0;
    localparam int SCD_PIN_DA1 = 1;
    localparam int SCD_PIN_DA2 = 2;
    localparam int SCD_PIN_MODE = 3;
    localparam int SCD_PIN_N = 4;
    // power-up presets of the destination registers
    localparam logic [SCD_SCALE_W-1:0] SCD_RST_CHAN = 76'h0;
    localparam logic [SCD_SCALE_W-1:0] SCD_RST_START = 76'h59682F00;
    localparam logic [SCD_SCALE_W-1:0] SCD_RST_STOP = 76'h9502F900;
    localparam logic [SCD_SCALE_W-1:0] SCD_RST_STEP = 76'hF4240;
    localparam logic [SCD_SCALE_W-1:0] SCD_RST_REF = 76'h989680;

    typedef enum logic [3:0] {
        SCD_DST_CHAN = 4'h0,
        SCD_DST_START = 4'h1,
        SCD_DST_STOP = 4'h2,
        SCD_DST_STEP = 4'h3,
        SCD_DST_REF = 4'h4
    } scd_dest_e;

    typedef struct packed {
        logic [SCD_SEL_W-1:0] dest_select_field;
        logic [SCD_MUL_W-1:0] mult;
        logic [SCD_VAL_W-1:0] value_field;
    } scd_cmd_s;

    typedef struct packed {
        logic [SCD_SEL_W-1:0] dest;
        logic [SCD_SCALE_W-1:0] value;
    } scd_scaled_s;
endpackage

// ===== src/scd_scaler.sv
/*
 * Iterative decimal scaler: value times ten to the power n, one decade
 * per clock. Assumes a new request only while busy is low.
 */
`timescale 1ns/1ns
module scd_scaler (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic go,
    input scd_pkg::scd_cmd_s cmd,
    output logic busy,
    output logic done,
    output scd_pkg::scd_scaled_s res
);
    import scd_pkg::*;

    logic [SCD_SCALE_W-1:0] acc;
    logic [SCD_MUL_W-1:0] n_left;
    logic [SCD_SEL_W-1:0] dest;
    logic [SCD_VAL_W-1:0] orig_val;
    logic [SCD_MUL_W-1:0] orig_n;

    function automatic logic [SCD_SCALE_W-1:0] pow10(input logic [3:0] n);
        logic [SCD_SCALE_W-1:0] p;
        p = 76'h1;
        for (int i = 0; i < 15; i++) begin
            if (i < int'(n)) begin
                p = SCD_SCALE_W'(p * 76'hA);
            end
        end
        return p;
    endfunction

    // x*10 as two shifts and an add, avoids a wide multiplier
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy <= 1'b0;
            done <= 1'b0;
            acc <= '0;
            n_left <= '0;
            dest <= '0;
            res <= '0;
            orig_val <= '0;
            orig_n <= '0;
        end else begin
            done <= 1'b0;
            if (go && !busy) begin
                acc <= SCD_SCALE_W'(cmd.value_field);
                n_left <= cmd.mult;
                dest <= cmd.dest_select_field;
                orig_val <= cmd.value_field;
                orig_n <= cmd.mult;
                busy <= 1'b1;
            end else if (busy) begin
                if (n_left == 4'h0) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    res <= '{dest: dest, value: acc};
                end else begin
                    acc <= SCD_SCALE_W'((acc << 3) + (acc << 1));
                    n_left <= n_left - 4'h1;
                end
            end
        end
    end

    property p_scale_exact;
        @(posedge core_clk) disable iff (rst)
        done |-> res.value == SCD_SCALE_W'(orig_val * pow10(orig_n));
    endproperty
    a_scale_exact: assert property (p_scale_exact)
        else $error("scaled value differs from value times 10^n");
endmodule

// ===== bench/scd_master.sv
/*
 * Bus master model for the command decoder: three-wire and two-wire
 * serial frames, driven from core_clk rising edges.
 * Assumes the bench builds the two-wire data wire from pin0 and the
 * device acknowledge enable, and feeds it back as sda_wire.
 */
`timescale 1ns/1ns
module scd_master (
    input wire logic core_clk,
    input wire logic sda_wire,
    output logic mode_sel,
    output logic pin0,
    output logic pin1,
    output logic pin2
);
    // idle levels: select and both two-wire lines high, clock low
    initial begin
        mode_sel = 1'b0;
        pin0 = 1'b1;
        pin1 = 1'b1;
        pin2 = 1'b0;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic set_mode(input logic m);
        cyc(1); // callers may return on a falling edge
        mode_sel <= m;
        cyc(8);
    endtask

    // one framed word, msb first; nbits other than 32 only for refusals
    task automatic tw_frame(input logic [31:0] w, input int nbits);
        logic [32:0] sh;
        sh = {w, 1'b0};
        cyc(4); // select high gap between frames
        pin0 <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            pin1 <= sh[32];
            sh = sh << 1;
            cyc(4);
            pin2 <= 1'b1;
            cyc(4);
            pin2 <= 1'b0;
        end
        cyc(4);
        pin0 <= 1'b1;
        pin1 <= ~pin1; // released data line keeps no stale value
    endtask

    task automatic i2c_start();
        cyc(1); // drive only just after a rising edge
        pin0 <= 1'b1;
        cyc(4);
        pin1 <= 1'b1;
        cyc(4);
        pin0 <= 1'b0; // data falls while clock high
        cyc(4);
        pin1 <= 1'b0;
        cyc(4);
    endtask

    // stop ends every full command, never a repeated start
    task automatic i2c_stop();
        pin0 <= 1'b0;
        cyc(4);
        pin1 <= 1'b1;
        cyc(4);
        pin0 <= 1'b1;
        cyc(4);
    endtask

    // eight data bits, then a released ninth clock for the acknowledge
    task automatic i2c_byte(input logic [7:0] b, output int ack);
        for (int i = 7; i >= 0; i--) begin
            pin0 <= b[i];
            cyc(4);
            pin1 <= 1'b1;
            cyc(4);
            pin1 <= 1'b0;
        end
        pin0 <= 1'b1;
        cyc(4);
        pin1 <= 1'b1;
        cyc(3);
        ack = (sda_wire === 1'b0) ? 1 : 0;
        cyc(1);
        pin1 <= 1'b0;
    endtask

    // address byte plus nbytes data bytes, stop optional
    task automatic i2c_cmd(input logic [6:0] addr, input logic [31:0] w,
            input int nbytes, input bit stop, output int acks);
        logic [39:0] f;
        int a;
        f = {addr, 1'b0, w};
        acks = 0;
        i2c_start();
        for (int k = 0; k <= nbytes; k++) begin
            i2c_byte(f[39-8*k -: 8], a);
            acks += a;
        end
        if (stop) begin
            i2c_stop();
        end
    endtask
endmodule

// ===== bench/scd_decoder_tb.sv
/*
 * Self-checking bench of the command decoder: both serial links,
 * scaling, the five destinations and refused frames.
 * Assumes the master model and the package; sda is open drain.
 */
`timescale 1ns/1ns
module scd_decoder_tb;
    import scd_pkg::*;
    localparam logic [6:0] DEV_ADDR = 7'h3A;
    logic core_clk;
    logic rst;
    logic mode_sel;
    logic pin0;
    logic pin1;
    logic pin2;
    logic sda;
    logic da0_out;
    logic da0_oe;
    logic reg_update;
    logic [SCD_SCALE_W-1:0] channel_num;
    logic [SCD_SCALE_W-1:0] start_freq;
    logic [SCD_SCALE_W-1:0] stop_freq;
    logic [SCD_SCALE_W-1:0] step_freq;
    logic [SCD_SCALE_W-1:0] ref_freq;
    logic [SCD_SCALE_W-1:0] op_freq;
    logic [SCD_SCALE_W-1:0] shadow [5];
    int fails;
    int n_checks;

    // wired-and of pull-up, master and device acknowledge
    assign sda = pin0 & ~da0_oe;

    scd_decoder #(.SLAVE_ADDR(DEV_ADDR)) u_scd_decoder (
        .core_clk(core_clk), .rst(rst), .da0_in(sda), .da1_in(pin1),
        .da2_in(pin2), .i2c_mode(mode_sel), .da0_out(da0_out),
        .da0_oe(da0_oe), .channel_num(channel_num),
        .start_freq(start_freq), .stop_freq(stop_freq),
        .step_freq(step_freq), .ref_freq(ref_freq), .op_freq(op_freq),
        .reg_update(reg_update));

    scd_master u_scd_master (.core_clk(core_clk), .sda_wire(sda),
        .mode_sel(mode_sel), .pin0(pin0), .pin1(pin1), .pin2(pin2));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    function automatic logic [SCD_SCALE_W-1:0] scaled(input logic [31:0] w);
        logic [SCD_SCALE_W-1:0] r;
        r = SCD_SCALE_W'(w[23:0]);
        for (int i = 0; i < w[27:24]; i++) begin
            r = r * 76'hA;
        end
        return r;
    endfunction

    task automatic chk(input logic [SCD_SCALE_W-1:0] got,
            input logic [SCD_SCALE_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk_regs();
        chk(channel_num, shadow[0]);
        chk(start_freq, shadow[1]);
        chk(stop_freq, shadow[2]);
        chk(step_freq, shadow[3]);
        chk(ref_freq, shadow[4]);
        chk(op_freq, shadow[1] + shadow[0] * shadow[3]);
    endtask

    // bounded wait for the update pulse; a lost pulse ends the run
    task automatic wait_upd(input int want);
        int seen;
        seen = 0;
        for (int i = 0; i < 40 && seen == 0; i++) begin
            @(negedge core_clk);
            if (reg_update === 1'b1) seen = 1;
        end
        chk(76'(seen), 76'(want));
        if (want == 1 && seen == 0) begin
            tally_and_finish();
        end else begin
            if (seen == 1) begin
                @(negedge core_clk);
                chk(76'(reg_update), 76'h0);
                @(negedge core_clk);
            end
            chk_regs();
        end
    endtask

    task automatic send3(input logic [31:0] w, input int nbits,
            input int want);
        u_scd_master.tw_frame(w, nbits);
        if (want == 1) shadow[w[31:28]] = scaled(w);
        wait_upd(want);
    endtask

    task automatic t_dests();
        logic [31:0] cmds [6] = '{32'h0000_0003, 32'h1316_E360,
            32'h222F_AF08, 32'h3FFF_FFFF, 32'h410F_4240, 32'h0000_0007};
        foreach (cmds[i]) send3(cmds[i], 32, 1);
        $display("test dests done");
    endtask

    // reserved selects and short or long frames write nothing
    task automatic t_refuse();
        send3(32'h5000_0001, 32, 0);
        send3(32'hF200_0009, 32, 0);
        send3(32'h0000_0005, 31, 0);
        send3(32'h0000_0005, 33, 0);
        $display("test refuse done");
    endtask

    task automatic t_i2c();
        int acks;
        u_scd_master.set_mode(1'b1);
        u_scd_master.i2c_cmd(DEV_ADDR, 32'h0100_0004, 4, 1, acks);
        chk(76'(acks), 76'h5);
        shadow[0] = 76'h28;
        wait_upd(1);
        u_scd_master.i2c_cmd(DEV_ADDR ^ 7'h01, 32'h0000_0009, 4, 1, acks);
        chk(76'(acks), 76'h0);
        wait_upd(0);
        // partial command then a fresh start: only the second counts
        u_scd_master.i2c_cmd(DEV_ADDR, 32'h1000_0001, 2, 0, acks);
        chk(76'(acks), 76'h3);
        u_scd_master.i2c_cmd(DEV_ADDR, 32'h0000_0002, 4, 1, acks);
        shadow[0] = 76'h2;
        wait_upd(1);
        $display("test i2c done");
    endtask

    // reset, presets, then the scenarios
    initial begin
        fails = 0;
        n_checks = 0;
        rst = 1'b1;
        shadow = '{SCD_RST_CHAN, SCD_RST_START, SCD_RST_STOP, SCD_RST_STEP,
            SCD_RST_REF};
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(negedge core_clk);
        chk_regs();
        chk(76'(da0_oe), 76'h0);
        chk(76'(da0_out), 76'h0);
        $display("test reset done");
        t_dests();
        t_refuse();
        t_i2c();
        tally_and_finish();
    end
endmodule
